// >>> design/psup_defs.svh
// constants for the power fault supervisor: thresholds, strap codes, timing
`ifndef PSUP_DEFS_SVH
`define PSUP_DEFS_SVH

`define PSUP_LOCK_MIN_MV 16'h0B22
`define PSUP_LOCK_MAX_MV 16'h3E80
`define PSUP_LOCK_LOW_MV 16'h0BB8
`define PSUP_LOCK_OPEN_MV 16'h1194
`define PSUP_LOCK_HIGH_MV 16'h2A30
`define PSUP_STRAP_LOW 2'h0
`define PSUP_STRAP_OPEN 2'h1
`define PSUP_STRAP_HIGH 2'h2
`define PSUP_OV_PCT_DEF 8'h0F
`define PSUP_PCT_FULL 9'h064
`define PSUP_OT_LIMIT_DEF 8'h7D
`define PSUP_OT_HYST 9'h00F
`define PSUP_CLK_HZ 40000000
`define PSUP_TICK_MS 1
`define PSUP_CYC_PER_MS (`PSUP_CLK_HZ / 1000 * `PSUP_TICK_MS)
`define PSUP_SRC_UV 0
`define PSUP_SRC_OV 1
`define PSUP_SRC_OC 2
`define PSUP_SRC_OT 3

`endif

// >>> design/psup_pkg.sv
// types shared by the power fault supervisor modules
package psup_pkg;
   typedef enum logic [2:0] {
      PSUP_RESP_CONT, PSUP_RESP_DLY, PSUP_RESP_IMM, PSUP_RESP_RETRY_CNT, PSUP_RESP_RETRY_INF
   } psup_resp_t;
   typedef enum logic [2:0] {CH_IDLE, CH_DLY, CH_OFF, CH_RETRY, CH_LATCH} psup_chan_state_t;
   typedef enum logic [2:0] {SEQ_OFF, SEQ_DELAY, SEQ_RAMP, SEQ_HOLD, SEQ_RUN} psup_seq_t;
   typedef struct packed {
      logic valid;
      psup_resp_t mode;
      logic [2:0] retry_max;
      logic [7:0] delay_ms;
   } psup_resp_cfg_t;
   typedef struct packed {
      psup_chan_state_t state;
      logic [7:0] cnt;
      logic [2:0] retries;
      logic event_p;
   } psup_chan_st_t;
   typedef struct packed {
      psup_seq_t seq;
      logic [15:0] div;
      logic tick;
      logic en_q;
      logic [7:0] dly_cnt;
      logic [23:0] ramp_cnt;
      logic [23:0] acc;
      logic [15:0] work;
      logic [15:0] delta;
      logic down;
      logic pb_ov;
      logic hs;
      logic ls;
      logic good;
      logic [3:0] flags;
      logic alert;
   } psup_main_st_t;
endpackage : psup_pkg

// >>> design/psup_fault_chan.sv
// one fault source: response mode sequencing and retry counting
`timescale 1ns/1ps
`include "psup_defs.svh"
module psup_fault_chan (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic fault_live,
   input wire logic clear_ok,
   input wire psup_pkg::psup_resp_cfg_t cfg,
   input wire logic restart_cmd,
   output logic shut,
   output logic event_p
);
   psup_pkg::psup_chan_st_t st, n;
   psup_pkg::psup_resp_t mode;

   // unprogrammed source falls back to immediate shutdown
   assign mode = cfg.valid ? cfg.mode : psup_pkg::PSUP_RESP_IMM;
   assign shut = (st.state == psup_pkg::CH_OFF) || (st.state == psup_pkg::CH_RETRY) ||
                 (st.state == psup_pkg::CH_LATCH);
   assign event_p = st.event_p;

   // response state machine
   always_comb begin
      n = st;
      n.event_p = 1'b0;
      unique case (st.state)
         psup_pkg::CH_IDLE: begin
            if (fault_live) begin
               n.event_p = 1'b1;
               n.cnt = 8'h00;
               unique case (mode)
                  psup_pkg::PSUP_RESP_CONT: n.state = psup_pkg::CH_IDLE;
                  psup_pkg::PSUP_RESP_DLY: n.state = psup_pkg::CH_DLY;
                  psup_pkg::PSUP_RESP_IMM: n.state = psup_pkg::CH_OFF;
                  psup_pkg::PSUP_RESP_RETRY_INF: n.state = psup_pkg::CH_RETRY;
                  psup_pkg::PSUP_RESP_RETRY_CNT: begin
                     // exhausted count keeps the output down
                     if (st.retries >= cfg.retry_max) n.state = psup_pkg::CH_LATCH;
                     else n.state = psup_pkg::CH_RETRY;
                  end
                  default: n.state = psup_pkg::CH_OFF;
               endcase
            end
         end
         psup_pkg::CH_DLY: begin
            if (!fault_live) begin
               n.state = psup_pkg::CH_IDLE;
            end else if (tick) begin
               n.cnt = st.cnt + 8'h01;
               if (n.cnt >= cfg.delay_ms) n.state = psup_pkg::CH_LATCH;
            end
         end
         psup_pkg::CH_OFF: begin
            if (clear_ok) n.state = psup_pkg::CH_IDLE;
         end
         psup_pkg::CH_RETRY: begin
            if (tick) begin
               n.cnt = st.cnt + 8'h01;
               if (n.cnt >= cfg.delay_ms) begin
                  // check after the wait, else wait again
                  n.cnt = 8'h00;
                  if (clear_ok) begin
                     n.state = psup_pkg::CH_IDLE;
                     if (st.retries != 3'h7) n.retries = st.retries + 3'h1;
                  end
               end
            end
         end
         psup_pkg::CH_LATCH: begin
            if (restart_cmd) n.state = psup_pkg::CH_IDLE;
         end
         default: n.state = psup_pkg::CH_IDLE;
      endcase
      if (restart_cmd) n.retries = 3'h0;
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   cont_never_off_a: assert property (
      (st.state == psup_pkg::CH_IDLE) && (mode == psup_pkg::PSUP_RESP_CONT) |=> !shut)
      else $error("continue mode shut the output");
   exhausted_latch_a: assert property (
      (st.state == psup_pkg::CH_IDLE) && fault_live && !restart_cmd &&
      (mode == psup_pkg::PSUP_RESP_RETRY_CNT) && (st.retries >= cfg.retry_max)
      |=> (st.state == psup_pkg::CH_LATCH))
      else $error("exhausted retries did not latch off");
   imm_clear_a: assert property (
      (st.state == psup_pkg::CH_OFF) && clear_ok |=> !shut)
      else $error("cleared fault did not re-enable");
endmodule : psup_fault_chan

// >>> design/psup_supervisor.sv
// top of the power fault supervisor: thresholds, start-up sequencer, sticky flags
`timescale 1ns/1ps
`include "psup_defs.svh"
module psup_supervisor #(
   parameter int unsigned CYC_PER_MS = `PSUP_CYC_PER_MS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic enable_cmd,
   input wire logic [15:0] vin_mv,
   input wire logic [1:0] input_low_lockout,
   input wire logic host_lock_valid,
   input wire logic [15:0] host_lock_mv,
   input wire logic [15:0] output_sense_input,
   input wire logic [15:0] target_mv,
   input wire logic host_ov_pct_valid,
   input wire logic [7:0] host_ov_pct,
   input wire logic oc_fault_in,
   input wire logic signed [7:0] die_temp_c,
   input wire logic host_ot_valid,
   input wire logic [7:0] host_ot_limit,
   input wire psup_pkg::psup_resp_cfg_t [3:0] resp_cfg,
   input wire logic ov_crowbar_sel,
   input wire logic ext_clock_sel,
   input wire logic share_group,
   input wire logic track_en,
   input wire logic [7:0] delay_ms,
   input wire logic [7:0] ramp_ms,
   input wire logic [3:0] flag_clear,
   output logic high_side_en,
   output logic low_side_en,
   output logic power_good_output,
   output logic [15:0] work_target_mv,
   output logic [3:0] fault_flags,
   output logic alert
);
   localparam logic [15:0] DIV_LAST = 16'(CYC_PER_MS - 1);

   psup_pkg::psup_main_st_t st, n;
   logic [15:0] strap_mv, lock_mv;
   logic [7:0] ov_pct, ot_limit;
   logic [23:0] ov_rhs, sense_scaled, samp_scaled, ramp_cyc, acc_sum;
   logic signed [8:0] temp_ext, ot_lim_ext, ot_rel_ext;
   logic uv_live, ov_live, ot_live, ot_clear, pb_en, crowbar_eff, ramp_last, any_shut;
   logic restart_cmd;
   logic [3:0] flt_live, flt_clear, shut, ev;
   psup_pkg::psup_resp_cfg_t [3:0] cfg_eff;

   // strap decode; the unconnected level is the default
   always_comb begin
      unique case (input_low_lockout)
         `PSUP_STRAP_LOW: strap_mv = `PSUP_LOCK_LOW_MV;
         `PSUP_STRAP_HIGH: strap_mv = `PSUP_LOCK_HIGH_MV;
         default: strap_mv = `PSUP_LOCK_OPEN_MV;
      endcase
   end

   // host value wins over the strap, clamped into the legal span
   always_comb begin
      lock_mv = strap_mv;
      if (host_lock_valid) begin
         if (host_lock_mv < `PSUP_LOCK_MIN_MV) lock_mv = `PSUP_LOCK_MIN_MV;
         else if (host_lock_mv > `PSUP_LOCK_MAX_MV) lock_mv = `PSUP_LOCK_MAX_MV;
         else lock_mv = host_lock_mv;
      end
   end
   assign uv_live = vin_mv < lock_mv;

   // overvoltage: sense * 100 > target * (100 + pct), no divider needed
   assign ov_pct = host_ov_pct_valid ? host_ov_pct : `PSUP_OV_PCT_DEF;
   assign ov_rhs = 24'(target_mv) * 24'(`PSUP_PCT_FULL + {1'b0, ov_pct});
   assign sense_scaled = 24'(output_sense_input) * 24'(`PSUP_PCT_FULL);
   assign samp_scaled = sense_scaled;
   assign ov_live = sense_scaled > ov_rhs;

   // die temperature against limit, restart only below limit minus hysteresis
   assign ot_limit = host_ot_valid ? host_ot_limit : `PSUP_OT_LIMIT_DEF;
   assign temp_ext = {die_temp_c[7], die_temp_c};
   assign ot_lim_ext = $signed({1'b0, ot_limit});
   assign ot_rel_ext = ot_lim_ext - $signed(`PSUP_OT_HYST);
   assign ot_live = temp_ext > ot_lim_ext;
   assign ot_clear = temp_ext < ot_rel_ext;

   // per-source fault and clear conditions
   assign flt_live[`PSUP_SRC_UV] = uv_live;
   assign flt_live[`PSUP_SRC_OV] = ov_live | st.pb_ov;
   assign flt_live[`PSUP_SRC_OC] = oc_fault_in;
   assign flt_live[`PSUP_SRC_OT] = ot_live;
   assign flt_clear[`PSUP_SRC_UV] = !uv_live;
   assign flt_clear[`PSUP_SRC_OV] = !ov_live;
   assign flt_clear[`PSUP_SRC_OC] = !oc_fault_in;
   assign flt_clear[`PSUP_SRC_OT] = ot_clear;

   // crowbar only with the internal clock; the overvoltage source shuts or retries
   assign crowbar_eff = ov_crowbar_sel && !ext_clock_sel;
   always_comb begin
      cfg_eff = resp_cfg;
      if (resp_cfg[`PSUP_SRC_OV].mode != psup_pkg::PSUP_RESP_RETRY_CNT) begin
         cfg_eff[`PSUP_SRC_OV].mode = psup_pkg::PSUP_RESP_IMM;
      end
   end

   assign restart_cmd = enable_cmd && !st.en_q;
   assign any_shut = |shut;

   // one response channel per fault source
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
         psup_fault_chan u_chan (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .tick(st.tick),
            .fault_live(flt_live[gi]),
            .clear_ok(flt_clear[gi]),
            .cfg(cfg_eff[gi]),
            .restart_cmd(restart_cmd),
            .shut(shut[gi]),
            .event_p(ev[gi])
         );
      end
   endgenerate

   // ramp length in cycles and rate accumulator
   assign ramp_cyc = 24'(ramp_ms) * 24'(CYC_PER_MS);
   assign ramp_last = (st.ramp_cnt + 24'h000001) >= ramp_cyc;
   assign acc_sum = st.acc + 24'(st.delta);
   assign pb_en = !(share_group && track_en);

   // sequencer, divider, drivers and flags
   always_comb begin
      n = st;
      n.en_q = enable_cmd;
      n.pb_ov = 1'b0;
      n.tick = 1'b0;
      if (st.div == DIV_LAST) begin
         n.div = 16'h0000;
         n.tick = 1'b1;
      end else begin
         n.div = st.div + 16'h0001;
      end
      unique case (st.seq)
         psup_pkg::SEQ_OFF: begin
            n.good = 1'b0;
            n.work = 16'h0000;
            // crowbar holds the low side while the overvoltage channel stays shut
            n.hs = 1'b0;
            n.ls = shut[`PSUP_SRC_OV] && crowbar_eff;
            if (enable_cmd && !any_shut && !uv_live) begin
               n.seq = psup_pkg::SEQ_DELAY;
               n.dly_cnt = 8'h00;
               n.ls = 1'b0;
            end
         end
         psup_pkg::SEQ_DELAY: begin
            if (st.tick) n.dly_cnt = st.dly_cnt + 8'h01;
            if (st.dly_cnt >= delay_ms) begin
               // output sampled at delay expiry, before any ramp
               n.ramp_cnt = 24'h000000;
               n.acc = 24'h000000;
               n.down = 1'b0;
               if (pb_en && (samp_scaled > ov_rhs)) begin
                  n.pb_ov = 1'b1;
                  n.seq = psup_pkg::SEQ_OFF;
               end else if (!pb_en || (output_sense_input < target_mv)) begin
                  n.work = pb_en ? output_sense_input : 16'h0000;
                  n.delta = target_mv - n.work;
                  n.hs = 1'b1;
                  n.ls = 1'b1;
                  n.seq = psup_pkg::SEQ_RAMP;
               end else begin
                  n.work = output_sense_input;
                  n.hs = 1'b1;
                  n.ls = 1'b1;
                  n.seq = psup_pkg::SEQ_HOLD;
               end
            end
         end
         psup_pkg::SEQ_RAMP: begin
            // spread the step count evenly over the ramp time
            n.ramp_cnt = st.ramp_cnt + 24'h000001;
            n.acc = acc_sum;
            if ((acc_sum >= ramp_cyc) && (st.work != target_mv)) begin
               n.acc = acc_sum - ramp_cyc;
               n.work = st.down ? (st.work - 16'h0001) : (st.work + 16'h0001);
            end
            if (ramp_last) begin
               n.work = target_mv;
               n.good = 1'b1;
               n.seq = psup_pkg::SEQ_RUN;
            end
         end
         psup_pkg::SEQ_HOLD: begin
            n.ramp_cnt = st.ramp_cnt + 24'h000001;
            if (ramp_last) begin
               // power-good first, then walk down to target
               n.good = 1'b1;
               n.down = 1'b1;
               n.delta = st.work - target_mv;
               n.ramp_cnt = 24'h000000;
               n.acc = 24'h000000;
               n.seq = psup_pkg::SEQ_RAMP;
            end
         end
         psup_pkg::SEQ_RUN: begin
            n.work = target_mv;
         end
         default: n.seq = psup_pkg::SEQ_OFF;
      endcase
      // shutdown or disable leaves any active state at once
      if ((st.seq != psup_pkg::SEQ_OFF) && (any_shut || !enable_cmd)) begin
         n.seq = psup_pkg::SEQ_OFF;
         n.hs = 1'b0;
         n.ls = 1'b0;
         n.good = 1'b0;
      end
      if (ov_live) n.good = 1'b0;
      // sticky flags: a new event wins over a clear in the same cycle
      n.flags = ev | (st.flags & ~flag_clear);
      n.alert = |n.flags;
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end

   assign high_side_en = st.hs;
   assign low_side_en = st.ls;
   assign power_good_output = st.good;
   assign work_target_mv = st.work;
   assign fault_flags = st.flags;
   assign alert = st.alert;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_hold_expire;
      (st.seq == psup_pkg::SEQ_HOLD) && ramp_last && !any_shut && enable_cmd && !ov_live;
   endsequence
   sequence s_down_ramp;
      (st.seq == psup_pkg::SEQ_RAMP) && st.good && st.down;
   endsequence

   ov_good_drop_a: assert property (ov_live |=> !power_good_output)
      else $error("power-good stayed up during overvoltage");
   uv_no_start_a: assert property (
      (st.seq == psup_pkg::SEQ_OFF) && uv_live |=> (st.seq == psup_pkg::SEQ_OFF))
      else $error("started while input below lockout");
   lock_span_a: assert property (
      (lock_mv >= `PSUP_LOCK_MIN_MV) && (lock_mv <= `PSUP_LOCK_MAX_MV))
      else $error("lockout threshold out of range");
   pb_ov_block_a: assert property (
      (st.seq == psup_pkg::SEQ_DELAY) && (st.dly_cnt >= delay_ms) && pb_en &&
      (samp_scaled > ov_rhs) |=> (st.seq == psup_pkg::SEQ_OFF) && st.pb_ov ##1 shut[1])
      else $error("pre-bias overvoltage did not block start");
   hold_then_down_a: assert property (s_hold_expire |=> s_down_ramp)
      else $error("high pre-bias did not assert power-good and ramp down");
   ramp_end_a: assert property (
      (st.seq == psup_pkg::SEQ_RAMP) && ramp_last && !any_shut && enable_cmd
      |=> (work_target_mv == $past(target_mv)) && (st.seq == psup_pkg::SEQ_RUN))
      else $error("ramp did not land on target at ramp end");
   crowbar_hold_a: assert property (
      (st.seq == psup_pkg::SEQ_OFF) && shut[1] && crowbar_eff
      |=> low_side_en && !high_side_en)
      else $error("crowbar did not hold low side");
   sticky_set_a: assert property ((|ev) |=> ((fault_flags & $past(ev)) == $past(ev)))
      else $error("fault event lost from sticky flags");
   alert_fall_a: assert property ($fell(alert) |-> $past(|flag_clear))
      else $error("alert dropped without a host clear");

   // start-up decision edge at the end of the delay
   sequence s_delay_expire;
      (st.seq == psup_pkg::SEQ_DELAY) && (st.dly_cnt >= delay_ms) && !any_shut && enable_cmd;
   endsequence

   shut_stop_a: assert property (
      (st.seq != psup_pkg::SEQ_OFF) && any_shut |=> !high_side_en && !power_good_output)
      else $error("active fault did not stop the drivers");
   strap_pick_a: assert property (
      !host_lock_valid && (input_low_lockout == `PSUP_STRAP_HIGH)
      |-> (lock_mv == `PSUP_LOCK_HIGH_MV))
      else $error("high strap did not select its threshold");
   host_pick_a: assert property (
      host_lock_valid && (host_lock_mv >= `PSUP_LOCK_MIN_MV) &&
      (host_lock_mv <= `PSUP_LOCK_MAX_MV) |-> (lock_mv == host_lock_mv))
      else $error("host threshold did not override the strap");
   ext_no_bar_a: assert property (
      ext_clock_sel && (st.seq == psup_pkg::SEQ_OFF) |=> !low_side_en)
      else $error("low side held on with external clock");
   pb_low_a: assert property (
      s_delay_expire ##0 (pb_en && !(samp_scaled > ov_rhs) && (output_sense_input < target_mv))
      |=> high_side_en && low_side_en && (work_target_mv == $past(output_sense_input)))
      else $error("low pre-bias start did not begin at the sample");
   pb_high_a: assert property (
      s_delay_expire ##0 (pb_en && !(samp_scaled > ov_rhs) && !(output_sense_input < target_mv))
      |=> (st.seq == psup_pkg::SEQ_HOLD) && (work_target_mv == $past(output_sense_input)))
      else $error("high pre-bias did not hold the sample");
   pb_off_a: assert property (
      s_delay_expire ##0 !pb_en |=> (work_target_mv == 16'h0000))
      else $error("pre-bias used while sharing and tracking");
endmodule : psup_supervisor

// >>> bench/psup_stage_model.sv
// behavioural power stage and output node seen by the sense input
`timescale 1ns/1ps
module psup_stage_model (
   input wire logic high_side_en,
   input wire logic low_side_en,
   input wire logic [15:0] work_target_mv,
   input wire logic [15:0] prebias_mv,
   input wire logic [15:0] ov_add_mv,
   output logic [15:0] sense_mv
);
   // switching stage follows the working target, crowbar pulls to ground, idle keeps pre-bias
   always_comb begin
      if (high_side_en)
         sense_mv = work_target_mv + ov_add_mv;
      else if (low_side_en)
         sense_mv = ov_add_mv; // external source may still push the node up
      else
         sense_mv = prebias_mv + ov_add_mv;
   end
endmodule : psup_stage_model

// >>> bench/psup_supervisor_tb.sv
// self-checking bench for the power fault supervisor
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module psup_supervisor_tb;
   typedef struct packed {
      logic [1:0] strap;
      logic hv;
      logic [15:0] hmv;
      logic [15:0] vin;
      logic run;
   } psup_row_t;
   localparam psup_row_t ROWS [0:10] = '{
      '{2'h0, 1'b0, 16'h0000, 16'h0C1C, 1'b1}, '{2'h0, 1'b0, 16'h0000, 16'h0B54, 1'b0},
      '{2'h1, 1'b0, 16'h0000, 16'h1130, 1'b0}, '{2'h1, 1'b0, 16'h0000, 16'h11F8, 1'b1},
      '{2'h2, 1'b0, 16'h0000, 16'h29CC, 1'b0}, '{2'h2, 1'b0, 16'h0000, 16'h2A94, 1'b1},
      '{2'h3, 1'b0, 16'h0000, 16'h1130, 1'b0}, '{2'h2, 1'b1, 16'h07D0, 16'h0B54, 1'b1},
      '{2'h0, 1'b1, 16'h4E20, 16'h3A98, 1'b0}, '{2'h0, 1'b1, 16'h4E20, 16'h3EE4, 1'b1},
      '{2'h1, 1'b0, 16'h0000, 16'h1194, 1'b1}};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable_cmd = 1'b0;
   logic [15:0] vin_mv = 16'h2EE0;
   logic [1:0] input_low_lockout = 2'h1;
   logic host_lock_valid = 1'b0;
   logic [15:0] host_lock_mv = 16'h0000;
   logic [15:0] sense_mv;
   logic [15:0] target_mv = 16'h03E8;
   logic oc_fault_in = 1'b0;
   logic signed [7:0] die_temp_c = 8'h19;
   psup_pkg::psup_resp_cfg_t [3:0] resp_cfg = '0;
   logic ov_crowbar_sel = 1'b0;
   logic ext_clock_sel = 1'b0;
   logic share_group = 1'b0;
   logic track_en = 1'b0;
   logic [7:0] delay_ms = 8'h01;
   logic [7:0] ramp_ms = 8'h02;
   logic [3:0] flag_clear = 4'h0;
   logic [15:0] prebias_mv = 16'h0000;
   logic [15:0] ov_add_mv = 16'h0000;
   logic high_side_en, low_side_en, power_good_output, alert;
   logic [15:0] work_target_mv;
   logic [3:0] fault_flags;
   int err_total = 0;
   int checked = 0;
   int n;

   psup_supervisor #(.CYC_PER_MS(8)) i_psup_supervisor (
      .ref_clk(ref_clk), .rst_n(rst_n), .enable_cmd(enable_cmd), .vin_mv(vin_mv),
      .input_low_lockout(input_low_lockout), .host_lock_valid(host_lock_valid),
      .host_lock_mv(host_lock_mv), .output_sense_input(sense_mv), .target_mv(target_mv),
      .host_ov_pct_valid(1'b0), .host_ov_pct(8'h0F), .oc_fault_in(oc_fault_in),
      .die_temp_c(die_temp_c), .host_ot_valid(1'b0), .host_ot_limit(8'h7D),
      .resp_cfg(resp_cfg), .ov_crowbar_sel(ov_crowbar_sel), .ext_clock_sel(ext_clock_sel),
      .share_group(share_group), .track_en(track_en), .delay_ms(delay_ms), .ramp_ms(ramp_ms),
      .flag_clear(flag_clear), .high_side_en(high_side_en), .low_side_en(low_side_en),
      .power_good_output(power_good_output), .work_target_mv(work_target_mv),
      .fault_flags(fault_flags), .alert(alert));

   psup_stage_model i_psup_stage_model (
      .high_side_en(high_side_en), .low_side_en(low_side_en),
      .work_target_mv(work_target_mv), .prebias_mv(prebias_mv), .ov_add_mv(ov_add_mv),
      .sense_mv(sense_mv));

   // 40 MHz reference clock
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   // advance whole cycles, landing just after the rising edge
   task automatic step(input int c);
      repeat (c) @(posedge ref_clk);
      #2;
   endtask : step

   // bounded wait for the high-side driver to reach a level
   task automatic wait_hs(input logic v, input int c);
      int i;
      for (i = 0; i < c && high_side_en !== v; i++) step(1);
   endtask : wait_hs

   // cycles from drivers on until power-good
   task automatic wait_good(output int c);
      c = 0;
      while (power_good_output !== 1'b1 && c < 60) begin
         step(1);
         c++;
      end
   endtask : wait_good

   // drop and raise the run command: a restart
   task automatic kick();
      enable_cmd = 1'b0;
      step(2);
      enable_cmd = 1'b1;
   endtask : kick

   // one fault episode on the overcurrent input: off, then back on
   task automatic oc_episode();
      oc_fault_in = 1'b1;
      step(3);
      `CHK(high_side_en, 1'b0)
      oc_fault_in = 1'b0;
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
   endtask : oc_episode

   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // watchdog against a hang
   initial begin
      #(25 * 60000);
      err_total++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      step(6);
      `CHK({high_side_en, low_side_en, power_good_output, alert, fault_flags}, 8'h00)
      step(6);
      rst_n = 1'b1;
      foreach (ROWS[i]) begin
         enable_cmd = 1'b0;
         input_low_lockout = ROWS[i].strap;
         host_lock_valid = ROWS[i].hv;
         host_lock_mv = ROWS[i].hmv;
         vin_mv = ROWS[i].vin;
         step(3);
         enable_cmd = 1'b1;
         wait_hs(1'b1, 60);
         `CHK(high_side_en, ROWS[i].run)
      end
      input_low_lockout = 2'h1;
      host_lock_valid = 1'b0;
      vin_mv = 16'h2EE0;
      // low pre-bias: start from the sample, reach target in the ramp time
      prebias_mv = 16'h0258;
      kick();
      wait_hs(1'b1, 60);
      `CHK({high_side_en, low_side_en, work_target_mv}, {2'b11, 16'h0258})
      wait_good(n);
      `CHK((n > 13) && (n < 19), 1'b1)
      `CHK(work_target_mv, 16'h03E8)
      // high pre-bias: hold the sample, power-good, then ramp down
      prebias_mv = 16'h044C;
      kick();
      wait_hs(1'b1, 60);
      `CHK({high_side_en, low_side_en, work_target_mv}, {2'b11, 16'h044C})
      wait_good(n);
      `CHK((n > 13) && (n < 19), 1'b1)
      step(20);
      `CHK(work_target_mv, 16'h03E8)
      // pre-bias above the overvoltage limit: no start, sticky flag
      prebias_mv = 16'h04B0;
      kick();
      step(60);
      `CHK({high_side_en, fault_flags[1], alert}, 3'b011)
      prebias_mv = 16'h0000;
      wait_hs(1'b1, 60);
      `CHK({high_side_en, fault_flags[1]}, 2'b11)
      flag_clear = 4'hF;
      step(1);
      flag_clear = 4'h0;
      step(2);
      `CHK({fault_flags, alert}, 5'h00)
      // sharing with tracking: pre-bias ignored
      share_group = 1'b1;
      track_en = 1'b1;
      prebias_mv = 16'h0258;
      kick();
      wait_hs(1'b1, 60);
      `CHK(work_target_mv, 16'h0000)
      share_group = 1'b0;
      track_en = 1'b0;
      prebias_mv = 16'h0000;
      step(40);
      // overvoltage while running, default response
      ov_add_mv = 16'h00C8;
      step(1);
      `CHK(power_good_output, 1'b0)
      step(2);
      `CHK(high_side_en, 1'b0)
      ov_add_mv = 16'h0000;
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      // crowbar response, then external clock forces plain shutdown
      ov_crowbar_sel = 1'b1;
      ov_add_mv = 16'h0514;
      step(4);
      `CHK({high_side_en, low_side_en}, 2'b01)
      ext_clock_sel = 1'b1;
      step(2);
      `CHK({high_side_en, low_side_en}, 2'b00)
      ov_add_mv = 16'h0000;
      ext_clock_sel = 1'b0;
      ov_crowbar_sel = 1'b0;
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      // overcurrent: default, continue, delayed, counted, unlimited
      oc_episode();
      resp_cfg[2] = '{1'b1, psup_pkg::PSUP_RESP_CONT, 3'h0, 8'h00};
      oc_fault_in = 1'b1;
      step(10);
      `CHK({high_side_en, fault_flags[2]}, 2'b11)
      resp_cfg[2] = '{1'b1, psup_pkg::PSUP_RESP_DLY, 3'h0, 8'h02};
      oc_fault_in = 1'b0;
      step(3);
      oc_fault_in = 1'b1;
      step(4);
      `CHK(high_side_en, 1'b1)
      step(30);
      oc_fault_in = 1'b0;
      step(30);
      `CHK(high_side_en, 1'b0)
      kick();
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      resp_cfg[2] = '{1'b1, psup_pkg::PSUP_RESP_RETRY_CNT, 3'h1, 8'h01};
      oc_episode();
      oc_fault_in = 1'b1;
      step(3);
      oc_fault_in = 1'b0;
      step(60);
      `CHK(high_side_en, 1'b0)
      kick();
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      resp_cfg[2] = '{1'b1, psup_pkg::PSUP_RESP_RETRY_INF, 3'h0, 8'h01};
      repeat (2) oc_episode();
      // over-temperature with 15 degree re-enable band
      die_temp_c = 8'h7D;
      step(10);
      `CHK(high_side_en, 1'b1)
      die_temp_c = 8'h7E;
      step(3);
      `CHK(high_side_en, 1'b0)
      die_temp_c = 8'h6E;
      step(30);
      `CHK(high_side_en, 1'b0)
      die_temp_c = 8'h6D;
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      // input undervoltage: default shutdown and recovery, then continue mode
      vin_mv = 16'h0FA0;
      step(3);
      `CHK(high_side_en, 1'b0)
      vin_mv = 16'h2EE0;
      wait_hs(1'b1, 80);
      `CHK(high_side_en, 1'b1)
      resp_cfg[0] = '{1'b1, psup_pkg::PSUP_RESP_CONT, 3'h0, 8'h00};
      vin_mv = 16'h0FA0;
      step(10);
      `CHK(high_side_en, 1'b1)
      tally_and_finish();
   end
endmodule : psup_supervisor_tb
